// ===== include/knob_map.svh
// Constants for the knob decoder and LED panel
`ifndef KNOB_MAP_SVH
`define KNOB_MAP_SVH

// Clock period in ns, as run here
`define CLK_PERIOD_NS      40
// Contact must hold a level this long before it is believed
`define SETTLE_TIME_NS     1000000
`define SETTLE_CYCLES      (`SETTLE_TIME_NS / `CLK_PERIOD_NS)
`define SETTLE_CNT_W       16
// Indicator count
`define LED_COUNT          8
// Contact levels
`define CONTACT_CLOSED     1'b0
`define CONTACT_OPEN       1'b1

`endif

// ===== include/knob_pkg.sv
// Types for the knob decoder and LED panel
`default_nettype none
package knob_pkg;
    typedef enum logic [1:0] {
        AT_DETENT,
        LEAVING,
        MIDWAY,
        RETURNING
    } knob_state_t;
    typedef enum logic {
        DIR_CLOCKWISE,
        DIR_COUNTER
    } knob_dir_t;
endpackage
`default_nettype wire

// ===== hdl/contact_filter.sv
// Synchroniser and settle filter for one mechanical contact
`default_nettype none
`include "knob_map.svh"
module contact_filter #(
    parameter int unsigned SETTLE = `SETTLE_CYCLES
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic rawPin,
    output var  logic clean
);
    // ********************************
    // Two-stage synchroniser
    // ********************************
    logic                     syncFirst;
    logic                     syncSecond;
    logic [`SETTLE_CNT_W-1:0] settleCount;

    wire differs = syncSecond != clean;
    wire settled = settleCount == (`SETTLE_CNT_W)'(SETTLE - 1);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            syncFirst  <= `CONTACT_CLOSED;
            syncSecond <= `CONTACT_CLOSED;
        end else begin
            syncFirst  <= rawPin;
            syncSecond <= syncFirst;
        end
    end

    // ********************************
    // Settle counter
    // ********************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            settleCount <= '0;
            clean       <= `CONTACT_CLOSED;
        end else if (!differs) begin
            settleCount <= '0;
        end else if (settled) begin
            settleCount <= '0;
            clean       <= syncSecond;
        end else begin
            settleCount <= settleCount + 1'b1;
        end
    end
endmodule // contact_filter
`default_nettype wire

// ===== hdl/knob_panel.sv
// Knob step decoder and eight-LED indicator driver
`default_nettype none
`include "knob_map.svh"
module knob_panel
    import knob_pkg::*;
#(
    parameter int unsigned SETTLE = `SETTLE_CYCLES
) (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  quadrature_contact_first,
    input  wire logic                  quadrature_contact_second,
    input  wire logic                  knob_press_input,
    input  wire logic [`LED_COUNT-1:0] ledRequest,
    output var  logic                  quadPullUpEnable,
    output var  logic                  pressPullDownEnable,
    output var  logic                  stepPulse,
    output var  logic                  stepCounter,
    output var  logic                  knobPressed,
    output var  logic [`LED_COUNT-1:0] ledDrive
);
    // ********************************
    // Declarations
    // ********************************
    logic        cleanFirst;
    logic        cleanSecond;
    logic        pressSyncFirst;
    logic        pressSyncSecond;
    knob_state_t state;
    knob_state_t next_state;
    knob_dir_t   leaveDir;
    knob_dir_t   next_leaveDir;

    // ********************************
    // Contact filtering
    // ********************************
    // Each contact has its own synchroniser and settle counter
    contact_filter #(.SETTLE(SETTLE)) filterFirst (
        .clock  (clock),
        .rst_n  (rst_n),
        .rawPin (quadrature_contact_first),
        .clean  (cleanFirst)
    );
    contact_filter #(.SETTLE(SETTLE)) filterSecond (
        .clock  (clock),
        .rst_n  (rst_n),
        .rawPin (quadrature_contact_second),
        .clean  (cleanSecond)
    );

    // ********************************
    // Quadrature decode
    // ********************************
    // Patterns of the filtered contacts; low means closed
    wire bothClosed = cleanFirst == `CONTACT_CLOSED
                   && cleanSecond == `CONTACT_CLOSED;
    wire bothOpen   = cleanFirst == `CONTACT_OPEN
                   && cleanSecond == `CONTACT_OPEN;
    wire onlyFirst  = cleanFirst == `CONTACT_OPEN
                   && cleanSecond == `CONTACT_CLOSED;
    wire onlySecond = cleanFirst == `CONTACT_CLOSED
                   && cleanSecond == `CONTACT_OPEN;
    // The contact that opened first also closes first on a full step
    wire towardNext  = leaveDir == DIR_COUNTER ? onlyFirst : onlySecond;
    wire towardStart = leaveDir == DIR_COUNTER ? onlySecond : onlyFirst;
    wire stepDone    = state == RETURNING && bothClosed;
    wire stepDirCcw  = leaveDir == DIR_COUNTER;

    // ********************************
    // Step decode
    // ********************************
    // A return along the leaving pattern means the knob went back
    always_comb begin
        next_state    = state;
        next_leaveDir = leaveDir;
        unique case (state)
            AT_DETENT: begin
                if (onlyFirst) begin
                    next_state    = LEAVING;
                    next_leaveDir = DIR_CLOCKWISE;
                end else if (onlySecond) begin
                    next_state    = LEAVING;
                    next_leaveDir = DIR_COUNTER;
                end
            end
            LEAVING: begin
                if (bothOpen) begin
                    next_state = MIDWAY;
                end else if (bothClosed) begin
                    next_state = AT_DETENT;
                end
            end
            MIDWAY: begin
                if (bothClosed) begin
                    next_state = AT_DETENT;
                end else if (towardNext) begin
                    next_state = RETURNING;
                end else if (towardStart) begin
                    next_state = LEAVING;
                end
            end
            RETURNING: begin
                if (bothClosed) begin
                    next_state = AT_DETENT;
                end else if (bothOpen) begin
                    next_state = MIDWAY;
                end else if (towardStart) begin
                    next_state = LEAVING;
                end
            end
        endcase
    end

    // ********************************
    // Step state
    // ********************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= AT_DETENT;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            leaveDir <= DIR_CLOCKWISE;
        end else begin
            leaveDir <= next_leaveDir;
        end
    end

    // ********************************
    // Step outputs
    // ********************************
    // Direction is held between steps so a slow reader still sees it
    wire next_stepPulse   = stepDone;
    wire next_stepCounter = stepDone ? stepDirCcw : stepCounter;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stepPulse <= 1'b0;
        end else begin
            stepPulse <= next_stepPulse;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stepCounter <= 1'b0;
        end else begin
            stepCounter <= next_stepCounter;
        end
    end

    // ********************************
    // Knob press
    // ********************************
    // Two flops against metastability; no chatter filter on the press
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pressSyncFirst  <= 1'b0;
            pressSyncSecond <= 1'b0;
        end else begin
            pressSyncFirst  <= knob_press_input;
            pressSyncSecond <= pressSyncFirst;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            knobPressed <= 1'b0;
        end else begin
            knobPressed <= pressSyncSecond;
        end
    end

    // ********************************
    // Pull requests
    // ********************************
    wire                  next_quadPullUpEnable    = 1'b1;
    wire                  next_pressPullDownEnable = 1'b1;
    wire [`LED_COUNT-1:0] next_ledDrive            = ledRequest;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            quadPullUpEnable <= 1'b1;
        end else begin
            quadPullUpEnable <= next_quadPullUpEnable;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pressPullDownEnable <= 1'b1;
        end else begin
            pressPullDownEnable <= next_pressPullDownEnable;
        end
    end

    // ********************************
    // Indicator drive
    // ********************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ledDrive <= '0;
        end else begin
            ledDrive <= next_ledDrive;
        end
    end
endmodule // knob_panel
`default_nettype wire

// ===== bench/knob_encoder_model.sv
// Two-contact rotary encoder model
`default_nettype none
module knob_encoder_model (
    input  wire logic clock,
    input  wire logic go,
    input  wire logic ccw,
    input  wire logic bouncy,
    input  wire logic abort,
    input  wire logic turnBack,
    output var  logic busy,
    output var  logic chA,
    output var  logic chB
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {busy, chA, chB} = 3'h0;
    task automatic phase(input logic a, input logic b);
        logic [1:0] old;
        old = {chA, chB};
        repeat (bouncy ? 2 : 0) begin
            @(negedge clock) {chA, chB} = {a, b};
            @(negedge clock) {chA, chB} = old;
        end
        repeat (12) @(negedge clock) {chA, chB} = {a, b};
    endtask
    always @(posedge go) begin
        busy = 1'b1;
        if (ccw) phase(1'b0, 1'b1); else phase(1'b1, 1'b0);
        if (!abort) begin
            phase(1'b1, 1'b1);
            if (ccw ^ turnBack) phase(1'b1, 1'b0);
            else phase(1'b0, 1'b1);
        end
        phase(1'b0, 1'b0);
        busy = 1'b0;
    end
endmodule // knob_encoder_model
`default_nettype wire

// ===== bench/knob_panel_chk.sv
// Port assertions for the knob panel
`default_nettype none
`include "knob_map.svh"
module knob_panel_chk #(
    parameter int unsigned SETTLE = 4
) (
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic                  quadrature_contact_first,
    input wire logic                  quadrature_contact_second,
    input wire logic [`LED_COUNT-1:0] ledRequest,
    input wire logic                  quadPullUpEnable,
    input wire logic                  pressPullDownEnable,
    input wire logic                  stepPulse,
    input wire logic                  stepCounter,
    input wire logic [`LED_COUNT-1:0] ledDrive,
    input wire logic                  knob_press_input,
    input wire logic                  knobPressed
);
    wire logic closed = !(quadrature_contact_first
                          | quadrature_contact_second);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_pull; quadPullUpEnable && pressPullDownEnable; endproperty
    a_pull: assert property (p_pull) else $error("pull off");
    property p_led; $past(rst_n) |-> ledDrive == $past(ledRequest); endproperty
    a_led: assert property (p_led) else $error("led lag");
    property p_clean;
        stepPulse |-> closed && $past(closed, SETTLE);
    endproperty
    a_clean: assert property (p_clean) else $error("early step");
    property p_once; stepPulse |=> !stepPulse; endproperty
    a_once: assert property (p_once) else $error("long pulse");
    property p_dir; $changed(stepCounter) |-> stepPulse; endproperty
    a_dir: assert property (p_dir) else $error("stray dir");
    property p_press;
        $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n)
            |-> knobPressed == $past(knob_press_input, 3);
    endproperty
    a_press: assert property (p_press) else $error("press lag");
endmodule // knob_panel_chk
bind knob_panel knob_panel_chk #(.SETTLE(SETTLE)) chk (.clock, .rst_n,
    .quadrature_contact_first, .quadrature_contact_second, .ledRequest,
    .quadPullUpEnable, .pressPullDownEnable, .stepPulse, .stepCounter,
    .ledDrive, .knob_press_input, .knobPressed);
`default_nettype wire

// ===== bench/rotary_knob_decoder_led_panel_test.sv
// Self-checking bench for the knob panel
`default_nettype none
`include "knob_map.svh"
module rotary_knob_decoder_led_panel_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned SETTLE = 4;
    logic       clock = 1'b0, rst_n = 1'b0, go = 1'b0, ccw = 1'b0;
    logic       bouncy = 1'b0, abort = 1'b0, press = 1'b0, lastDir;
    logic [7:0] ledRequest = 8'h00;
    logic       turnBack = 1'b0;
    logic [2:0] pressLog = 3'h0;
    wire logic  chA, chB, busy, qPull, pPull, stepPulse, stepCounter;
    wire logic  knobPressed;
    wire logic  [7:0] ledDrive;
    int         badCount = 0, samplesChecked = 0, pulses = 0, expPulses = 0;
    integer     seed = 32'hfbd68ae6;
    always #20 clock = ~clock;
    knob_encoder_model enc (.clock, .go, .ccw, .bouncy, .abort, .turnBack,
        .busy, .chA, .chB);
    knob_panel #(.SETTLE(SETTLE)) uut (.clock, .rst_n,
        .quadrature_contact_first(chA), .quadrature_contact_second(chB),
        .knob_press_input(press), .ledRequest, .quadPullUpEnable(qPull),
        .pressPullDownEnable(pPull), .stepPulse, .stepCounter,
        .knobPressed, .ledDrive);
    always @(posedge clock) if (stepPulse === 1'b1) begin
        pulses++;
        lastDir = stepCounter;
    end
    // ****
    // Checking
    // ****
    function automatic int stepGain(input logic aborted, input logic reversed);
        return (aborted || reversed) ? 0 : 1;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic tallyAndFinish;
        $display("checks %0d bad %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #(8000 * 40);
        badCount++;
        tallyAndFinish;
    end
    initial begin
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        check({6'h00, pPull, qPull}, 8'h03);
        for (int i = 0; i < 24; i++) begin
            ledRequest = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($random(seed));
            press = 1'($random(seed));
            pressLog = {pressLog[1:0], press};
            @(negedge clock);
            check(ledDrive, ledRequest);
            check({7'h00, knobPressed}, {7'h00, pressLog[2]});
        end
        for (int i = 0; i < 14; i++) begin
            ccw = 1'($random(seed));
            bouncy = i > 1 ? 1'($random(seed)) : i[0];
            abort = i == 2 || (i != 3 && 2'($random(seed)) == 2'h0);
            turnBack = i == 3 || 3'($random(seed)) == 3'h0;
            go = 1'b1;
            @(negedge clock);
            go = 1'b0;
            for (int n = 0; n < 200 && busy; n++) @(negedge clock);
            repeat (SETTLE + 8) @(negedge clock);
            expPulses += stepGain(abort, turnBack);
            check(8'(pulses), 8'(expPulses));
            if (stepGain(abort, turnBack) == 1) begin
                check({7'h00, lastDir}, {7'h00, ccw});
            end
        end
        tallyAndFinish;
    end
endmodule // rotary_knob_decoder_led_panel_test
`default_nettype wire
